// ==== rtl/wdcr1_pkg.sv ====
// Package for the watchdog control register one block
package wdcr1_pkg;
  localparam logic [7:0] WDCR1_OFF_CS1 = 8'h00;
  localparam logic [7:0] WDCR1_OFF_CNTH = 8'h08;
  localparam logic [7:0] WDCR1_OFF_CNTL = 8'h0C;
  localparam logic [7:0] WDCR1_OFF_TOVH = 8'h10;
  localparam logic [7:0] WDCR1_OFF_TOVL = 8'h14;
  localparam logic [7:0] WDCR1_OFF_IST = 8'h18;
  localparam logic [7:0] WDCR1_OFF_ICLR = 8'h1C;
  localparam logic [7:0] WDCR1_OFF_IEN = 8'h20;
  localparam logic [7:0] WDCR1_OFF_MODE = 8'h24;
  localparam logic [7:0] WDCR1_CS1_RESET = 8'h80;
  localparam logic [7:0] WDCR1_TOVL_RESET = 8'h04;
  localparam logic [7:0] WDCR1_TOVH_RESET = 8'h00;
  localparam int WDCR1_BIT_EN = 7;
  localparam int WDCR1_BIT_INT = 6;
  localparam int WDCR1_BIT_UPD = 5;
  localparam int WDCR1_BIT_TSTH = 4;
  localparam int WDCR1_BIT_TSTL = 3;
  localparam int WDCR1_BIT_DBG = 2;
  localparam int WDCR1_BIT_WAIT = 1;
  localparam int WDCR1_BIT_STOP = 0;
  localparam logic [15:0] WDCR1_UNLOCK1 = 16'h20C5;
  localparam logic [15:0] WDCR1_UNLOCK2 = 16'h28D9;
  localparam logic [15:0] WDCR1_REFRESH1 = 16'h02A6;
  localparam logic [15:0] WDCR1_REFRESH2 = 16'h80B4;
  localparam int WDCR1_SEQ_CLKS = 16;
  localparam int WDCR1_UPD_CLKS = 128;
  localparam int WDCR1_RST_DELAY_CLKS = 128;
  localparam logic [1:0] WDCR1_TST_OFF = 2'h0;
  localparam logic [1:0] WDCR1_TST_USER = 2'h1;
  localparam logic [1:0] WDCR1_TST_LOW = 2'h2;
  localparam logic [1:0] WDCR1_TST_HIGH = 2'h3;
  localparam int WDCR1_IRQ_W = 3;
  localparam int WDCR1_IRQ_TMO = 0;
  localparam int WDCR1_IRQ_ILL = 1;
  localparam int WDCR1_IRQ_UNL = 2;
  localparam int WDCR1_CLK_HZ = 10000000;
  typedef enum logic [3:0] {
    WDCR1_S_IDLE = 4'h1,
    WDCR1_S_SEQ = 4'h2,
    WDCR1_S_OPEN = 4'h4,
    WDCR1_S_FIRE = 4'h8
  } wdcr1_state_t;
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } wdcr1_apb_req_t;
  typedef struct packed {
    logic chip_debug;
    logic chip_wait;
    logic chip_stop;
  } wdcr1_mode_t;
endpackage

// ==== rtl/wdcr1_cmp.sv ====
// Counter against timeout comparison, honouring the fast test field
`timescale 1ns/1ps
module wdcr1_cmp
  import wdcr1_pkg::*;
(
  input wire logic [15:0] count_i,
  input wire logic [15:0] timeout_i,
  input wire logic [1:0] test_sel_i,
  output logic hit_o
);
  always_comb begin
    case (test_sel_i)
      WDCR1_TST_LOW: hit_o = (count_i[7:0] >= timeout_i[7:0]);
      WDCR1_TST_HIGH: hit_o = (count_i[15:8] >= timeout_i[15:8]);
      default: hit_o = (count_i >= timeout_i);
    endcase
  end
endmodule

// ==== rtl/wdcr1_top.sv ====
// Watchdog control register one with counter, unlock and reset logic
`timescale 1ns/1ps
// Overview of operation
// - The counter runs only while the enable bit 7 is set.
// - All configuration fields are fixed by the first CS1 write after reset.
// - With bit 6 set a timeout or illegal write raises an interrupt first.
// - With bit 6 set the reset follows 128 clocks after vector fetch.
// - With bit 5 clear any later configuration write forces a reset.
// - With bit 5 set writes are taken for 128 clocks after unlock.
// - Test field 00 is disabled and 01 is user mode, full compare.
// - Test field 10 compares only the low bytes.
// - Test field 11 compares only the high bytes.
// - The test field clears only on power-on reset.
// - In debug mode the watchdog runs only with bit 2 set.
// - In wait mode the watchdog runs only with bit 1 set.
// - In stop mode the watchdog runs only with bit 0 set.
// - With bit 5 set, writing 0x20C5 then 0x28D9 within 16 clocks unlocks.
module wdcr1_top
  import wdcr1_pkg::*;
(
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic por_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic chip_debug_i,
  input wire logic chip_wait_i,
  input wire logic chip_stop_i,
  input wire logic vector_fetch_i,
  output logic irq_o,
  output logic wdog_reset_o
);
  localparam int SEQ_W = $clog2(WDCR1_SEQ_CLKS + 1);
  localparam int UPD_W = $clog2(WDCR1_UPD_CLKS + 1);
  localparam int DLY_W = $clog2(WDCR1_RST_DELAY_CLKS + 1);
  localparam logic [SEQ_W-1:0] SEQ_MAX = SEQ_W'(WDCR1_SEQ_CLKS);
  localparam logic [UPD_W-1:0] UPD_MAX = UPD_W'(WDCR1_UPD_CLKS);
  localparam logic [DLY_W-1:0] DLY_MAX = DLY_W'(WDCR1_RST_DELAY_CLKS);

  typedef struct packed {
    logic [7:0] cs1;
    logic cfg_done;
    logic [15:0] tov;
    logic [15:0] cnt;
    logic [7:0] lo_stage;
    wdcr1_state_t st;
    logic seq_refresh;
    logic [SEQ_W-1:0] seq_cnt;
    logic [UPD_W-1:0] upd_cnt;
    logic pend;
    logic fetched;
    logic [DLY_W-1:0] dly_cnt;
    logic [WDCR1_IRQ_W-1:0] ist;
    logic [WDCR1_IRQ_W-1:0] ien;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic irq;
    logic wrst;
    logic [1:0] sdbg;
    logic [1:0] swait;
    logic [1:0] sstop;
  } wdcr1_regs_t;

  wdcr1_regs_t q, d;
  logic hit;
  logic [1:0] tst_keep_q;
  wdcr1_apb_req_t req;
  wdcr1_mode_t mode;

  function automatic logic [15:0] cnt_word(input logic [7:0] hi,
                                           input logic [7:0] lo);
    cnt_word = {hi, lo};
  endfunction

  assign req = '{psel: psel_i, penable: penable_i, pwrite: pwrite_i,
                 paddr: paddr_i, pwdata: pwdata_i};
  assign mode = '{chip_debug: q.sdbg[1], chip_wait: q.swait[1],
                  chip_stop: q.sstop[1]};

  wdcr1_cmp u_cmp (
    .count_i(q.cnt),
    .timeout_i(q.tov),
    .test_sel_i(tst_keep_q),
    .hit_o(hit)
  );

  always_comb begin
    logic acc;
    logic wr;
    logic cfg_ok;
    logic run;
    logic ill;
    logic tmo;
    logic [15:0] word;
    acc = 1'b0;
    wr = 1'b0;
    cfg_ok = 1'b0;
    run = 1'b0;
    ill = 1'b0;
    tmo = 1'b0;
    word = 16'h0000;
    d = q;
    d.sdbg = {q.sdbg[0], chip_debug_i};
    d.swait = {q.swait[0], chip_wait_i};
    d.sstop = {q.sstop[0], chip_stop_i};
    d.pready = 1'b0;
    d.pslverr = 1'b0;
    acc = req.psel && req.penable && !q.pready;
    wr = acc && req.pwrite;
    cfg_ok = !q.cfg_done || (q.st == WDCR1_S_OPEN);
    if (q.seq_cnt != '0) begin
      d.seq_cnt = q.seq_cnt - 1'b1;
    end
    case (q.st)
      WDCR1_S_SEQ: begin
        if (q.seq_cnt == '0) begin
          d.st = WDCR1_S_IDLE;
        end
      end
      WDCR1_S_OPEN: begin
        d.upd_cnt = q.upd_cnt - 1'b1;
        if (q.upd_cnt == UPD_W'(1)) begin
          d.st = WDCR1_S_IDLE;
          d.cfg_done = 1'b1;
        end
      end
      WDCR1_S_FIRE: begin
      end
      default: begin
      end
    endcase
    if (acc) begin
      d.pready = 1'b1;
      d.prdata = 32'h0000_0000;
      case (req.paddr)
        WDCR1_OFF_CS1: begin
          d.prdata[7:0] = {q.cs1[7:5], tst_keep_q, q.cs1[2:0]};
          if (wr && cfg_ok) begin
            d.cs1 = req.pwdata[7:0];
            d.cfg_done = 1'b1;
          end else if (wr && !q.cs1[WDCR1_BIT_UPD]) begin
            ill = 1'b1;
          end
        end
        WDCR1_OFF_TOVH: begin
          d.prdata[7:0] = q.tov[15:8];
          if (wr && cfg_ok) begin
            d.tov[15:8] = req.pwdata[7:0];
          end else if (wr && !q.cs1[WDCR1_BIT_UPD]) begin
            ill = 1'b1;
          end
        end
        WDCR1_OFF_TOVL: begin
          d.prdata[7:0] = q.tov[7:0];
          if (wr && cfg_ok) begin
            d.tov[7:0] = req.pwdata[7:0];
          end else if (wr && !q.cs1[WDCR1_BIT_UPD]) begin
            ill = 1'b1;
          end
        end
        WDCR1_OFF_CNTH: begin
          d.prdata[7:0] = q.cnt[15:8];
          if (wr) begin
            word = cnt_word(req.pwdata[7:0], q.lo_stage);
            if (q.seq_cnt == '0 || q.st != WDCR1_S_SEQ) begin
              d.lo_stage = 8'h00;
              if (word == WDCR1_UNLOCK1 && q.cs1[WDCR1_BIT_UPD]) begin
                d.st = WDCR1_S_SEQ;
                d.seq_refresh = 1'b0;
                d.seq_cnt = SEQ_MAX;
              end else if (word == WDCR1_REFRESH1) begin
                d.st = WDCR1_S_SEQ;
                d.seq_refresh = 1'b1;
                d.seq_cnt = SEQ_MAX;
              end else if (word != WDCR1_UNLOCK1) begin
                ill = 1'b1;
              end else begin
                ill = 1'b1;
              end
            end else if (!q.seq_refresh && word == WDCR1_UNLOCK2) begin
              d.st = WDCR1_S_OPEN;
              d.upd_cnt = UPD_MAX;
              d.seq_cnt = '0;
            end else if (q.seq_refresh && word == WDCR1_REFRESH2) begin
              d.st = WDCR1_S_IDLE;
              d.cnt = 16'h0000;
              d.seq_cnt = '0;
            end else begin
              ill = 1'b1;
            end
          end
        end
        WDCR1_OFF_CNTL: begin
          d.prdata[7:0] = q.cnt[7:0];
          if (wr) begin
            d.lo_stage = req.pwdata[7:0];
          end
        end
        WDCR1_OFF_IST: begin
          d.prdata[WDCR1_IRQ_W-1:0] = q.ist;
        end
        WDCR1_OFF_ICLR: begin
          if (wr) begin
            d.ist = q.ist & ~req.pwdata[WDCR1_IRQ_W-1:0];
          end
        end
        WDCR1_OFF_IEN: begin
          d.prdata[WDCR1_IRQ_W-1:0] = q.ien;
          if (wr) begin
            d.ien = req.pwdata[WDCR1_IRQ_W-1:0];
          end
        end
        WDCR1_OFF_MODE: begin
          d.prdata[2:0] = {mode.chip_debug, mode.chip_wait, mode.chip_stop};
        end
        default: begin
          d.pslverr = 1'b1;
        end
      endcase
    end
    run = q.cs1[WDCR1_BIT_EN];
    if (mode.chip_debug && !q.cs1[WDCR1_BIT_DBG]) run = 1'b0;
    if (mode.chip_wait && !q.cs1[WDCR1_BIT_WAIT]) run = 1'b0;
    if (mode.chip_stop && !q.cs1[WDCR1_BIT_STOP]) run = 1'b0;
    if (run && q.st != WDCR1_S_OPEN) begin
      d.cnt = q.cnt + 16'h0001;
      tmo = hit;
    end
    if (!q.pend && (tmo || ill)) begin
      d.pend = 1'b1;
      d.st = WDCR1_S_FIRE;
      if (!q.cs1[WDCR1_BIT_INT]) begin
        d.wrst = 1'b1;
      end else begin
        d.fetched = 1'b0;
        d.dly_cnt = DLY_MAX;
      end
    end
    if (q.pend && q.cs1[WDCR1_BIT_INT]) begin
      if (!q.fetched && vector_fetch_i) begin
        d.fetched = 1'b1;
      end
      if (q.fetched) begin
        d.dly_cnt = q.dly_cnt - 1'b1;
        if (q.dly_cnt == DLY_W'(1)) begin
          d.wrst = 1'b1;
        end
      end
    end
    if (tmo) d.ist[WDCR1_IRQ_TMO] = 1'b1;
    if (ill) d.ist[WDCR1_IRQ_ILL] = 1'b1;
    if (q.st == WDCR1_S_SEQ && d.st == WDCR1_S_OPEN) begin
      d.ist[WDCR1_IRQ_UNL] = 1'b1;
    end
    d.irq = (|(d.ist & d.ien)) ||
            (d.pend && q.cs1[WDCR1_BIT_INT]);
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      q <= '0;
      q.cs1 <= WDCR1_CS1_RESET;
      q.tov <= {WDCR1_TOVH_RESET, WDCR1_TOVL_RESET};
      q.st <= WDCR1_S_IDLE;
    end else begin
      q <= d;
    end
  end

  // Test field lives outside the ordinary reset
  always_ff @(posedge clk_i) begin
    if (por_i) begin
      tst_keep_q <= WDCR1_TST_OFF;
    end else if (!reset_i && psel_i && penable_i && pwrite_i && !q.pready &&
                 paddr_i == WDCR1_OFF_CS1 &&
                 (!q.cfg_done || q.st == WDCR1_S_OPEN)) begin
      tst_keep_q <= pwdata_i[WDCR1_BIT_TSTH:WDCR1_BIT_TSTL];
    end
  end

  assign prdata_o = q.prdata;
  assign pready_o = q.pready;
  assign pslverr_o = q.pslverr;
  assign irq_o = q.irq;
  assign wdog_reset_o = q.wrst;
endmodule

// ==== dv/wdcr1_asserts.sv ====
// Port assertions for the watchdog control register one block
`timescale 1ns/1ps
module wdcr1_asserts
  import wdcr1_pkg::*;
(
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic pready_o,
  input wire logic pslverr_o,
  input wire logic vector_fetch_i,
  input wire logic irq_o,
  input wire logic wdog_reset_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);
  logic take;
  logic bad_hi;
  assign take = psel_i && penable_i && !pready_o;
  // High byte that belongs to no known counter word
  assign bad_hi = !(pwdata_i[7:0] inside {8'h20, 8'h28, 8'h02, 8'h80});
  rdy_wait_a: assert property (take |=> pready_o)
    else $error("Access phase not answered");
  rdy_pulse_a: assert property (pready_o |=> !pready_o)
    else $error("Ready held too long");
  err_map_a: assert property (take && paddr_i > 8'h24 |=> pslverr_o)
    else $error("Unmapped access not refused");
  err_only_a: assert property (pslverr_o |-> pready_o)
    else $error("Error without ready");
  rst_stick_a: assert property (wdog_reset_o |=> wdog_reset_o)
    else $error("Forced reset dropped");
  rst_hold_a: assert property ($rose(vector_fetch_i) && irq_o &&
    !wdog_reset_o |=> !wdog_reset_o [*8])
    else $error("Reset too soon after fetch");
  rst_clear_a: assert property (disable iff (1'b0)
    reset_i |=> !wdog_reset_o && !irq_o)
    else $error("Outputs not cleared by reset");
  ill_word_a: assert property (take && pwrite_i &&
    paddr_i == WDCR1_OFF_CNTH && bad_hi |-> ##[1:4] (wdog_reset_o || irq_o))
    else $error("Illegal counter word ignored");
  cover property ($rose(irq_o));
  cover property ($rose(wdog_reset_o));
  cover property (pslverr_o);
endmodule

bind wdcr1_top wdcr1_asserts u_asserts (.clk_i(clk_i), .reset_i(reset_i),
  .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
  .paddr_i(paddr_i), .pwdata_i(pwdata_i), .pready_o(pready_o),
  .pslverr_o(pslverr_o), .vector_fetch_i(vector_fetch_i), .irq_o(irq_o),
  .wdog_reset_o(wdog_reset_o));

// ==== dv/watchdog_control_reg_one_tb.sv ====
// Self-checking bench for the watchdog control register one block
`timescale 1ns/1ps
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin \
  miscompares++; $display("Error %0t got %h exp %h", $time, a, b); end end
module watchdog_control_reg_one_tb;
  import wdcr1_pkg::*;
  typedef struct packed {
    logic [31:0] d;
    logic [31:0] m;
    logic e;
  } wdcr1_note_t;
  logic clk_i = 0;
  logic reset_i = 1;
  logic por_i = 1;
  logic vector_fetch_i = 0;
  wdcr1_apb_req_t req = '0;
  wdcr1_mode_t md = '0;
  logic [31:0] prdata_o;
  logic pready_o, pslverr_o, irq_o, wdog_reset_o;
  logic [31:0] rnd = 32'h960AE48D;
  int miscompares = 0;
  int comparisons = 0;
  int n;
  wdcr1_note_t q[$];
  wdcr1_note_t nt;
  always #50 clk_i = ~clk_i;
  wdcr1_top dut (.clk_i(clk_i), .reset_i(reset_i), .por_i(por_i),
    .psel_i(req.psel), .penable_i(req.penable), .pwrite_i(req.pwrite),
    .paddr_i(req.paddr), .pwdata_i(req.pwdata), .prdata_o(prdata_o),
    .pready_o(pready_o), .pslverr_o(pslverr_o),
    .chip_debug_i(md.chip_debug), .chip_wait_i(md.chip_wait),
    .chip_stop_i(md.chip_stop), .vector_fetch_i(vector_fetch_i),
    .irq_o(irq_o), .wdog_reset_o(wdog_reset_o));
  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction
  task automatic stop_test();
    $display("Counts: %0d miscompares, %0d comparisons", miscompares,
      comparisons);
    if (miscompares == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic xfer(input logic w, input logic [7:0] a,
    input logic [31:0] d, input logic [31:0] m, input logic e);
    int k;
    @(posedge clk_i);
    req <= '{1'b1, 1'b0, w, a, d};
    q.push_back('{d & m, m, e});
    @(posedge clk_i);
    req.penable <= 1'b1;
    k = 0;
    do begin
      @(posedge clk_i);
      k++;
    end while (pready_o !== 1'b1 && k < 20);
    req.psel <= 1'b0;
    req.penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d, 32'h0, 1'b0);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b0, a, d, 32'hFF, 1'b0);
  endtask
  // Waits for irq_o (sel high) or the forced reset, cycles land in n
  task automatic wt(input logic sel, input int lim);
    n = 0;
    while ((sel ? irq_o : wdog_reset_o) !== 1'b1 && n < lim) begin
      @(posedge clk_i);
      n++;
    end
  endtask
  task automatic rst(input logic p, input logic [2:0] m);
    @(posedge clk_i);
    reset_i <= 1'b1;
    por_i <= p;
    md <= m;
    repeat (3) @(posedge clk_i);
    reset_i <= 1'b0;
    por_i <= 1'b0;
  endtask
  always @(posedge clk_i) begin
    if (pready_o === 1'b1 && q.size() > 0) begin
      nt = q.pop_front();
      `CHK(prdata_o & nt.m, nt.d)
      `CHK(pslverr_o, nt.e)
    end
  end
  initial begin
    #3000000;
    miscompares++;
    stop_test();
  end
  initial begin
    rst(1'b1, 3'h1);
    rd(WDCR1_OFF_CS1, 32'h80);
    wr(WDCR1_OFF_CS1, 32'h28);
    md <= '0;
    rd(WDCR1_OFF_CS1, 32'h28);
    wr(WDCR1_OFF_CS1, 32'hFF);
    rd(WDCR1_OFF_CS1, 32'h28);
    `CHK(wdog_reset_o, 1'b0)
    xfer(1'b0, 8'h40, 32'h0, 32'h0, 1'b1);
    wr(WDCR1_OFF_CNTL, 32'hC5);
    wr(WDCR1_OFF_CNTH, 32'h20);
    wr(WDCR1_OFF_CNTL, 32'hD9);
    wr(WDCR1_OFF_CNTH, 32'h28);
    rd(WDCR1_OFF_IST, 32'h4);
    `CHK(irq_o, 1'b0)
    wr(WDCR1_OFF_IEN, 32'h4);
    repeat (2) @(posedge clk_i);
    `CHK(irq_o, 1'b1)
    wr(WDCR1_OFF_ICLR, 32'h4);
    repeat (2) @(posedge clk_i);
    `CHK(irq_o, 1'b0)
    rd(WDCR1_OFF_IST, 32'h0);
    // Low-byte test mode with a high timeout byte that must be ignored
    wr(WDCR1_OFF_TOVH, 32'h01);
    wr(WDCR1_OFF_CS1, 32'hD0);
    rd(WDCR1_OFF_CS1, 32'hD0);
    wt(1'b1, 200);
    `CHK(irq_o, 1'b1)
    `CHK(wdog_reset_o, 1'b0)
    vector_fetch_i <= 1'b1;
    @(posedge clk_i);
    vector_fetch_i <= 1'b0;
    wt(1'b0, 300);
    `CHK((n >= 126 && n <= 130), 1'b1)
    rst(1'b0, 3'h1);
    rd(WDCR1_OFF_CS1, 32'h90);
    wr(WDCR1_OFF_CNTH, 32'h55);
    wt(1'b0, 10);
    `CHK(wdog_reset_o, 1'b1)
    rst(1'b1, 3'h1);
    wr(WDCR1_OFF_CS1, 32'h00);
    wr(WDCR1_OFF_TOVL, 32'h10);
    wt(1'b0, 10);
    `CHK(wdog_reset_o, 1'b1)
    for (int k = 0; k < 3; k++) begin
      rnd = xs(rnd);
      rst(1'b1, 3'h1 << k);
      rd(WDCR1_OFF_MODE, 32'h1 << k);
      wr(WDCR1_OFF_CS1, {24'h0, 5'h13, rnd[2:0]});
      wt(1'b0, 20);
      `CHK(wdog_reset_o, rnd[k])
    end
    stop_test();
  end
endmodule
